// *** tb_top.sv ***
// Self-checking bench of the virtual position window switches.
`timescale 1ns/100ps
module tb_top;
	import vpws_pkg::*;
	typedef struct packed {
		logic        rot;
		logic        fb;
		logic [31:0] b1;
		logic [31:0] b2;
		logic [31:0] cp;
		logic [31:0] fp;
		logic        ex;
	} vpws_row_t;
	logic                          clk = 1'b0;
	logic                          arst_n = 1'b0;
	vpws_pos_t [NUM_AX-1:0]        axis_pos = '0;
	logic [NUM_AX-1:0]             abs_detect = 8'hFD;
	logic [NUM_AX-1:0]             zero_init_done = 8'hFB;
	logic [NUM_AX-1:0]             ref_return_done = 8'h00;
	logic [ADDR_W-1:0]             reg_addr = 12'h000;
	logic [DATA_W-1:0]             reg_wdata = 32'h00000000;
	logic                          reg_wr = 1'b0;
	logic                          reg_rd = 1'b0;
	logic [DATA_W-1:0]             reg_rdata;
	logic [NUM_SW-1:0]             position_window_switch;
	logic [23:0]                   image_q;
	logic [31:0]                   rd_v;
	int                            errors = 0;
	int                            n_checks = 0;
	// Linear rows first, then rotary; positions are in 0.001 units.
	vpws_row_t rows [17] = '{
		'{1'b0, 1'b0, 32'h64, 32'hC8, 32'h96, 32'h0, 1'b1},
		'{1'b0, 1'b0, 32'hC8, 32'h64, 32'h96, 32'h0, 1'b1},
		'{1'b0, 1'b0, 32'hC8, 32'h64, 32'hC9, 32'h0, 1'b0},
		'{1'b0, 1'b0, 32'h1F4, 32'h1F4, 32'h1F4, 32'h0, 1'b1},
		'{1'b0, 1'b0, 32'h1F4, 32'h1F4, 32'h1F5, 32'h0, 1'b0},
		'{1'b0, 1'b1, 32'h64, 32'hC8, 32'h96, 32'h3E7, 1'b0},
		'{1'b0, 1'b1, 32'h64, 32'hC8, 32'h3E7, 32'h96, 1'b1},
		'{1'b1, 1'b0, -32'sh7530, 32'h7530, 32'h55730, 32'h0, 1'b1},
		'{1'b1, 1'b0, -32'sh7530, 32'h7530, 32'h2BF20, 32'h0, 1'b0},
		'{1'b1, 1'b0, 32'h668A0, 32'hEA60, 32'h57E3F, 32'h0, 1'b1},
		'{1'b1, 1'b0, 32'h668A0, 32'hEA60, 32'h7530, 32'h0, 1'b0},
		'{1'b1, 1'b0, -32'sh61A80, -32'sh50910, 32'h2710, 32'h0, 1'b1},
		'{1'b1, 1'b0, 32'h61A80, 32'h7A120, 32'h64, 32'h0, 1'b0},
		'{1'b1, 1'b0, -32'sh61A80, -32'sh7A120, 32'h0, 32'h0, 1'b0},
		'{1'b1, 1'b0, -32'sh7530, 32'h5F370, 32'h30D40, 32'h0, 1'b1},
		'{1'b1, 1'b0, -32'sh7530, -32'sh50910, 32'h186A0, 32'h0, 1'b1},
		'{1'b1, 1'b0, -32'sh7530, -32'sh50910, 32'h2710, 32'h0, 1'b0}
	};

	// ----------------------------------------------------------------
	// Clock, design and far-side model
	// ----------------------------------------------------------------
	always #2 clk = ~clk;
	vpws_top i_dut (.clk(clk), .arst_n(arst_n), .axis_pos(axis_pos), .abs_detect(abs_detect),
		.zero_init_done(zero_init_done), .ref_return_done(ref_return_done), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.position_window_switch(position_window_switch));
	vpws_plc_model i_plc (.clk(clk), .arst_n(arst_n), .position_window_switch(position_window_switch),
		.image_q(image_q));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe, so they are taken just after that edge.
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 rd_v = reg_rdata;
	endtask : rd
	task automatic cfg(input int n, input logic [31:0] ax, b1, b2, fb);
		logic [11:0] a;
		a = 12'h200 + 12'(16 * n);
		wr(a, ax);
		wr(a + 12'h004, b1);
		wr(a + 12'h008, b2);
		wr(a + 12'h00C, fb);
	endtask : cfg
	// Two full normal periods guarantee at least one judge whatever the phase.
	task automatic judge();
		repeat (520) @(posedge clk);
	endtask : judge
	task automatic wait_bit0(input logic v);
		for (int i = 0; i < 300 && position_window_switch[0] !== v; i++) @(posedge clk);
		chk(32'(position_window_switch[0]), 32'(v), "output edge");
	endtask : wait_bit0
	task automatic report_and_stop();
		$display("errors=%0d n_checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		chk(32'(position_window_switch), 32'h0, "reset outputs");
		arst_n <= 1'b1;
		rd(CTRL_OFS);
		chk(rd_v, 32'h0, "ctrl reset");
		rd(ROTARY_OFS);
		chk(rd_v, 32'h0, "rotary reset");
		// Axis 2 is relative and axis 3 lacks its zero setting, so nothing may fire yet.
		cfg(0, 32'h1, 32'h64, 32'hC8, 32'h0);
		cfg(2, 32'h3, 32'h64, 32'hC8, 32'h0);
		axis_pos[0].cmd <= 32'h96;
		axis_pos[2].cmd <= 32'h96;
		judge();
		chk(32'(image_q), 32'h0, "before return");
		rd(EST_OFS);
		chk(rd_v, 32'hF9, "est before");
		@(posedge clk);
		ref_return_done[1] <= 1'b1;
		@(posedge clk);
		ref_return_done[1] <= 1'b0;
		judge();
		chk(32'(image_q), 32'h1, "after return");
		rd(EST_OFS);
		chk(rd_v, 32'hFB, "est after");
		foreach (rows[i]) begin
			wr(ROTARY_OFS, 32'(rows[i].rot));
			cfg(0, 32'h1, rows[i].b1, rows[i].b2, 32'(rows[i].fb));
			axis_pos[0].cmd <= rows[i].cp;
			axis_pos[0].fb  <= rows[i].fp;
			judge();
			chk(32'(image_q[0]), 32'(rows[i].ex), "table row");
		end
		wr(ROTARY_OFS, 32'h0);
		cfg(0, 32'h1, 32'h64, 32'hC8, 32'h0);
		cfg(23, 32'h1, 32'h64, 32'hC8, 32'h0);
		axis_pos[0].cmd <= 32'h96;
		judge();
		chk(32'(image_q), 32'h800001, "last switch");
		rd(STATUS_OFS);
		chk(rd_v, 32'h800001, "status");
		wr(12'h370, 32'h0);
		judge();
		chk(32'(image_q[23]), 32'h0, "axis cleared");
		wr(12'h370, 32'h1);
		judge();
		chk(32'(image_q[23]), 32'h1, "axis restored");
		// Lock onto a judge edge, then show the output holds until the next one.
		axis_pos[0].cmd <= 32'h0;
		wait_bit0(1'b0);
		axis_pos[0].cmd <= 32'h96;
		repeat (200) @(posedge clk);
		chk(32'(position_window_switch[0]), 32'h0, "held");
		repeat (60) @(posedge clk);
		chk(32'(position_window_switch[0]), 32'h1, "next judge");
		wr(CTRL_OFS, 32'h1);
		repeat (300) @(posedge clk);
		axis_pos[0].cmd <= 32'h0;
		wait_bit0(1'b0);
		axis_pos[0].cmd <= 32'h96;
		repeat (60) @(posedge clk);
		chk(32'(position_window_switch[0]), 32'h1, "fast judge");
		wr(STATUS_OFS, 32'hFFFFFFFF);
		rd(STATUS_OFS);
		chk(rd_v, 32'h800001, "status read only");
		wr(12'h370, 32'h9);
		judge();
		chk(32'(image_q), 32'h1, "axis beyond last");
		rd(12'h100);
		chk(rd_v, 32'h0, "unmapped");
		rd(12'h205);
		chk(rd_v, 32'h0, "misaligned");
		wr(ROTARY_OFS, 32'h000001FF);
		rd(ROTARY_OFS);
		chk(rd_v, 32'hFF, "rotary field");
		// A reset in mid-run clears every output at once and forgets the reference return.
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(position_window_switch), 32'h0, "mid reset outputs");
		arst_n <= 1'b1;
		rd(ROTARY_OFS);
		chk(rd_v, 32'h0, "rotary after reset");
		cfg(0, 32'h1, 32'h64, 32'hC8, 32'h0);
		judge();
		chk(32'(image_q), 32'h0, "no return after reset");
		rd(EST_OFS);
		chk(rd_v, 32'hF9, "est recaptured");
		report_and_stop();
	end
endmodule : tb_top

// *** vpws_cmp.sv ***
// Window comparator of one position window switch, linear or rotary.
`timescale 1ns/100ps
module vpws_cmp (
	input  wire logic signed [vpws_pkg::POS_W-1:0] pos,
	input  wire logic signed [vpws_pkg::POS_W-1:0] bound1,
	input  wire logic signed [vpws_pkg::POS_W-1:0] bound2,
	input  wire logic                              rotary,
	output logic                                   hit
);
	import vpws_pkg::*;

	logic signed [POS_W:0] p;
	logic signed [POS_W:0] r1;
	logic signed [POS_W:0] r2;
	logic signed [POS_W:0] c1;
	logic signed [POS_W:0] c2;
	logic signed [POS_W:0] lo;
	logic signed [POS_W:0] hi;
	logic signed [POS_W:0] clo;
	logic signed [POS_W:0] chi;

	// ----------------------------------------------------------------
	// Window decision
	// ----------------------------------------------------------------
	// One bit wider than the bounds so that adding a full turn never wraps.
	always_comb begin
		p   = {pos[POS_W-1], pos};
		r1  = {bound1[POS_W-1], bound1};
		r2  = {bound2[POS_W-1], bound2};
		lo  = (r1 <= r2) ? r1 : r2;
		hi  = (r1 <= r2) ? r2 : r1;
		c1  = (r1 >= ROT_FULL) ? ROT_MAX : ((r1 <= ROT_MIN) ? ROT_MIN : r1);
		c2  = (r2 >= ROT_FULL) ? ROT_MAX : ((r2 <= ROT_MIN) ? ROT_MIN : r2);
		clo = (c1 <= c2) ? c1 : c2;
		chi = (c1 <= c2) ? c2 : c1;
		hit = 1'b0;
		if (!rotary) begin
			// Equal bounds leave a window of a single position.
			hit = (p >= lo) && (p <= hi);
		end else if ((r1 >= ROT_FULL && r2 >= ROT_FULL) || (r1 < ROT_MIN && r2 < ROT_MIN)) begin
			hit = 1'b0;
		end else if (r1 <= 0 && r2 >= ROT_FULL) begin
			hit = 1'b1;
		end else if (clo >= 0) begin
			hit = (p >= clo) && (p <= chi);
		end else if (chi <= 0) begin
			// A bound of zero maps to a full turn, which the position only shows as zero.
			hit = ((p >= clo + ROT_FULL) && (p <= chi + ROT_FULL)) || (chi == 0 && p == 0);
		end else begin
			hit = (p <= chi) || (p >= clo + ROT_FULL);
		end
	end

endmodule : vpws_cmp

// *** vpws_pkg.sv ***
// Shared constants, register map and carrier types of the virtual position window switches.
package vpws_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_SW = 24;
	localparam int NUM_AX = 8;
	localparam int AX_W   = 4;
	localparam int POS_W  = 32;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 9;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CTRL_OFS   = 12'h000;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
	localparam logic [ADDR_W-1:0] EST_OFS    = 12'h008;
	localparam logic [ADDR_W-1:0] ROTARY_OFS = 12'h00C;
	localparam logic [2:0]        SW_REGION  = 3'h1;
	localparam logic [1:0]        SW_AXIS_W  = 2'h0;
	localparam logic [1:0]        SW_B1_W    = 2'h1;
	localparam logic [1:0]        SW_B2_W    = 2'h2;
	localparam logic [1:0]        SW_CHECK_W = 2'h3;
	localparam int                CTRL_FAST_BIT = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [AX_W-1:0]   AXIS_RST   = 4'h0;
	localparam logic [POS_W-1:0]  BOUND_RST  = 32'h00000000;
	localparam logic [NUM_AX-1:0] ROTARY_RST = 8'h00;

	// ----------------------------------------------------------------
	// Rotary limits, one count is 0.001 degree
	// ----------------------------------------------------------------
	localparam logic signed [POS_W:0] ROT_FULL = 33'sh0_0005_7E40;
	localparam logic signed [POS_W:0] ROT_MAX  = 33'sh0_0005_7E3F;
	localparam logic signed [POS_W:0] ROT_MIN  = -33'sh0_0005_7E40;

	// ----------------------------------------------------------------
	// Comparison cycle timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 4;
	localparam int NORMAL_PERIOD_NS = 1000;
	localparam int FAST_PERIOD_NS   = 200;
	localparam int NORMAL_CYCLES    = (NORMAL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAST_CYCLES      = (FAST_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] NORMAL_RELOAD = CNT_W'(NORMAL_CYCLES - 1);
	localparam logic [CNT_W-1:0] FAST_RELOAD   = CNT_W'(FAST_CYCLES - 1);

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [AX_W-1:0]         axis;
		logic                    use_fb;
		logic signed [POS_W-1:0] bound1;
		logic signed [POS_W-1:0] bound2;
	} vpws_cfg_t;

	typedef struct packed {
		logic signed [POS_W-1:0] cmd;
		logic signed [POS_W-1:0] fb;
	} vpws_pos_t;

endpackage : vpws_pkg

// *** vpws_plc_model.sv ***
// Controller-side model that scans the switch outputs into its input image.
`timescale 1ns/100ps
module vpws_plc_model (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [23:0] position_window_switch,
	output logic      [23:0] image_q
);
	// ----------------------------------------------------------------
	// Input image
	// ----------------------------------------------------------------
	// The image is taken every clock, so a one-judge glitch is never hidden from the bench.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			image_q <= 24'h000000;
		end else begin
			image_q <= position_window_switch;
		end
	end
endmodule : vpws_plc_model

// *** vpws_top.sv ***
// Top of the virtual position window switches: registers, reference tracking and sampled comparison.
//
// How it works
// - Twenty-four switches, each with axis, two bounds, source choice and output.
// - Output is on while the chosen position is inside the window, otherwise off.
// - Positions compared are basic machine coordinates, without any coordinate offsets.
// - Each switch picks commanded or encoder feedback position.
// - Fast-judge control bit shortens the comparison cycle.
// - No output until the selected axis has its reference established.
// - Absolute axes are established at power-on if zero initial setting was done.
// - Relative axes establish on first reference return; all switches off until then.
// - Linear window runs from the smaller to the larger bound.
// - Equal linear bounds hit only at exactly that position.
// - Rotary bounds of opposite sign form the arc through zero.
// - Rotary bound at or above 360 is used as 359.999.
// - Rotary bound at or below minus 360 is used as minus 360.
// - Rotary bounds both out of range above or below never hit.
// - Rotary first bound at most zero, second at least 360: always on.
// - Rotary bounds both in minus 360 to zero span between them.
// - Axis zero disables a switch but keeps its bounds.
`timescale 1ns/100ps
module vpws_top (
	input  wire logic                                clk,
	input  wire logic                                arst_n,
	input  wire vpws_pkg::vpws_pos_t [vpws_pkg::NUM_AX-1:0] axis_pos,
	input  wire logic [vpws_pkg::NUM_AX-1:0]         abs_detect,
	input  wire logic [vpws_pkg::NUM_AX-1:0]         zero_init_done,
	input  wire logic [vpws_pkg::NUM_AX-1:0]         ref_return_done,
	input  wire logic [vpws_pkg::ADDR_W-1:0]         reg_addr,
	input  wire logic [vpws_pkg::DATA_W-1:0]         reg_wdata,
	input  wire logic                                reg_wr,
	input  wire logic                                reg_rd,
	output logic [vpws_pkg::DATA_W-1:0]              reg_rdata,
	output logic [vpws_pkg::NUM_SW-1:0]              position_window_switch
);
	import vpws_pkg::*;

	vpws_cfg_t           cfg_q [NUM_SW];
	logic                fast_q;
	logic [NUM_AX-1:0]   rotary_q;
	logic [NUM_AX-1:0]   est_q;
	logic [NUM_AX-1:0]   abs_cap_q;
	logic                started_q;
	logic [CNT_W-1:0]    cnt_q;
	logic                tick;
	logic                tick_q;
	vpws_pos_t [NUM_AX-1:0] samp_q;
	logic [NUM_SW-1:0]   hit;
	logic [NUM_SW-1:0]   en;
	logic [NUM_SW-1:0]   out_q;
	logic [DATA_W-1:0]   rdata_q;
	logic                rel_ok;
	logic                sw_sel;
	logic [4:0]          sw_idx;
	logic [1:0]          sw_word;
	logic [DATA_W-1:0]   rd_val;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	// Switch n occupies four words from 0x200 + 16 * n.
	assign sw_word = reg_addr[3:2];
	assign sw_idx  = reg_addr[8:4];
	assign sw_sel  = (reg_addr[11:9] == SW_REGION) && (sw_idx < 5'(NUM_SW)) && (reg_addr[1:0] == 2'h0);

	// Global controls: fast judge and the rotary axis mask.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fast_q   <= 1'b0;
			rotary_q <= ROTARY_RST;
		end else if (reg_wr) begin
			if (reg_addr == CTRL_OFS) begin
				fast_q <= reg_wdata[CTRL_FAST_BIT];
			end
			if (reg_addr == ROTARY_OFS) begin
				rotary_q <= reg_wdata[NUM_AX-1:0];
			end
		end
	end

	// Per switch settings; clearing the axis leaves the bounds untouched.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NUM_SW; i++) begin
				cfg_q[i].axis   <= AXIS_RST;
				cfg_q[i].use_fb <= 1'b0;
				cfg_q[i].bound1 <= BOUND_RST;
				cfg_q[i].bound2 <= BOUND_RST;
			end
		end else if (reg_wr && sw_sel) begin
			unique case (sw_word)
				SW_AXIS_W:  cfg_q[sw_idx].axis   <= reg_wdata[AX_W-1:0];
				SW_B1_W:    cfg_q[sw_idx].bound1 <= reg_wdata;
				SW_B2_W:    cfg_q[sw_idx].bound2 <= reg_wdata;
				SW_CHECK_W: cfg_q[sw_idx].use_fb <= reg_wdata[0];
			endcase
		end
	end

	// Read mux; unmapped addresses read as zero.
	always_comb begin
		rd_val = '0;
		if (sw_sel) begin
			unique case (sw_word)
				SW_AXIS_W:  rd_val = {{(DATA_W-AX_W){1'b0}}, cfg_q[sw_idx].axis};
				SW_B1_W:    rd_val = cfg_q[sw_idx].bound1;
				SW_B2_W:    rd_val = cfg_q[sw_idx].bound2;
				SW_CHECK_W: rd_val = {{(DATA_W-1){1'b0}}, cfg_q[sw_idx].use_fb};
			endcase
		end else if (reg_addr == CTRL_OFS) begin
			rd_val = {{(DATA_W-1){1'b0}}, fast_q};
		end else if (reg_addr == STATUS_OFS) begin
			rd_val = {{(DATA_W-NUM_SW){1'b0}}, out_q};
		end else if (reg_addr == EST_OFS) begin
			rd_val = {{(DATA_W-NUM_AX){1'b0}}, est_q};
		end else if (reg_addr == ROTARY_OFS) begin
			rd_val = {{(DATA_W-NUM_AX){1'b0}}, rotary_q};
		end
	end

	// Read data stand for exactly the cycle after the strobe.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= reg_rd ? rd_val : '0;
		end
	end

	// ----------------------------------------------------------------
	// Reference establishment
	// ----------------------------------------------------------------
	// The straps are caught in the first clocked cycle after reset, never by the reset itself.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			started_q <= 1'b0;
			abs_cap_q <= '0;
			est_q     <= '0;
		end else if (!started_q) begin
			started_q <= 1'b1;
			abs_cap_q <= abs_detect;
			est_q     <= abs_detect & zero_init_done;
		end else begin
			est_q <= est_q | (ref_return_done & ~abs_cap_q);
		end
	end

	// Any relative axis still without a reference holds every switch off.
	assign rel_ok = started_q && ((est_q | abs_cap_q) == {NUM_AX{1'b1}});

	// ----------------------------------------------------------------
	// Comparison cycle
	// ----------------------------------------------------------------
	// A fast-judge change takes effect at the next reload, so one cycle may still run long.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= NORMAL_RELOAD;
		end else if (cnt_q == '0) begin
			cnt_q <= fast_q ? FAST_RELOAD : NORMAL_RELOAD;
		end else begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign tick = (cnt_q == '0);

	// Positions are sampled on the tick and judged one cycle later.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_q <= 1'b0;
			samp_q <= '0;
		end else begin
			tick_q <= tick;
			if (tick) begin
				samp_q <= axis_pos;
			end
		end
	end

	// ----------------------------------------------------------------
	// Switches
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NUM_SW; g++) begin : g_sw
		logic [2:0]              ax;
		logic signed [POS_W-1:0] pos;

		assign ax  = 3'(cfg_q[g].axis - 4'h1);
		assign pos = cfg_q[g].use_fb ? samp_q[ax].fb : samp_q[ax].cmd;
		// Axis zero or beyond the last axis leaves the switch off.
		assign en[g] = (cfg_q[g].axis != 4'h0) && (cfg_q[g].axis <= 4'(NUM_AX))
			&& est_q[ax] && rel_ok;

		vpws_cmp u_cmp (
			.pos    (pos),
			.bound1 (cfg_q[g].bound1),
			.bound2 (cfg_q[g].bound2),
			.rotary (rotary_q[ax]),
			.hit    (hit[g])
		);
	end

	// Outputs change only on the judging cycle and hold otherwise.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			out_q <= '0;
		end else if (tick_q) begin
			out_q <= hit & en;
		end
	end

	assign position_window_switch = out_q;
	assign reg_rdata              = rdata_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	logic [CNT_W-1:0] gap_q;
	logic             fast_rl_q;

	// Cycles since the last tick, and the mode chosen at that reload.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gap_q     <= '0;
			fast_rl_q <= 1'b0;
		end else if (tick) begin
			gap_q     <= '0;
			fast_rl_q <= fast_q;
		end else begin
			gap_q <= gap_q + 1'b1;
		end
	end

	sequence s_judge;
		tick ##1 tick_q;
	endsequence

	out_hold_a: assert property (!tick_q |=> $stable(out_q))
		else $error("switch outputs changed outside a judging cycle");

	upd_match_a: assert property (s_judge |=> out_q == $past(hit & en))
		else $error("switch outputs differ from the judged windows");

	period_a: assert property ($past(started_q) && tick && $past(tick) == 1'b0 && gap_q != '0
		|-> gap_q == (fast_rl_q ? FAST_RELOAD : NORMAL_RELOAD))
		else $error("comparison cycle length wrong for the judge mode");

	rel_off_a: assert property (tick_q && !rel_ok |=> out_q == '0)
		else $error("switch on while a relative axis lacks a reference");

	abs_est_a: assert property (!started_q |=> est_q == $past(abs_detect & zero_init_done))
		else $error("absolute reference not taken from power-on state");

	rel_est_a: assert property (started_q
		|=> (est_q & $past(ref_return_done & ~abs_cap_q)) == $past(ref_return_done & ~abs_cap_q))
		else $error("reference return did not establish the axis");

	// References only accumulate; losing one would let a switch drop out with no reset in between.
	est_keep_a: assert property (started_q |=> ($past(est_q) & ~est_q) == '0)
		else $error("an established reference was lost");

	// Absolute axes are fixed by the capture after reset; a reference return must not touch them.
	abs_hold_a: assert property (started_q |=> (est_q & abs_cap_q) == ($past(est_q) & abs_cap_q))
		else $error("absolute axis reference changed after capture");

	// Samples move only on a tick, so a judge never sees a half-updated set of positions.
	samp_hold_a: assert property (!tick |=> $stable(samp_q))
		else $error("position samples changed between ticks");

	// Each tick reloads the counter with the length of the mode selected at that moment.
	reload_a: assert property (tick |=> cnt_q == ($past(fast_q) ? FAST_RELOAD : NORMAL_RELOAD))
		else $error("comparison counter reloaded with the wrong length");

	// Read data stand for the one cycle after the strobe and read as zero otherwise.
	rd_data_a: assert property (reg_rd |=> reg_rdata == $past(rd_val))
		else $error("read data differ from the addressed register");

	rd_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data present without a read strobe");

	for (genvar g = 0; g < NUM_SW; g++) begin : g_chk
		axis_off_a: assert property (tick_q && cfg_q[g].axis == 4'h0 |=> !out_q[g])
			else $error("switch with no axis drove its output");

		ref_gate_a: assert property (tick_q && !est_q[g_sw[g].ax] |=> !out_q[g])
			else $error("switch on before its axis had a reference");

		// An axis number beyond the last axis leaves the switch dark, like axis zero.
		axis_range_a: assert property (tick_q && cfg_q[g].axis > 4'(NUM_AX) |=> !out_q[g])
			else $error("switch with an unknown axis drove its output");

		// Rewriting the axis word must leave both stored bounds untouched.
		sequence s_axis_wr;
			reg_wr && sw_sel && sw_idx == 5'(g) && sw_word == SW_AXIS_W;
		endsequence

		bound_keep_a: assert property (s_axis_wr |=> $stable(cfg_q[g].bound1) && $stable(cfg_q[g].bound2))
			else $error("axis write disturbed the stored bounds");
	end

endmodule : vpws_top
